// ===== hw/sbst_consts.vh
// constants for the sram boundary scan tap
// assumes inclusion by bare name from the hw design files
// What this block does
// (R1) five tms-high rising tck edges reset tap
// (R2) tap reset never disturbs memory operation
// (R3) power-up reset leaves tdo high impedance
// (R4) exactly one scan register selected by instruction
// (R5) sample on rising tck, drive on falling
// (R6) three-bit instruction, idcode at reset
// (R7) capture-ir loads 01 into low bits
// (R8) bypass single bit, cleared at capture
// (R9) boundary chain captures pins, then shifts
// (R10) tdi feeds chain msb, lsb drives tdo
// (R11) idcode captures fixed 32-bit value
// (R12) new instruction effective only at update-ir
// (R13) controller never loads reserved codes
// (R14) sample-z selects chain, floats output bus
// (R15) sample/preload snapshots all pins at capture
// (R16) capture shifts out while preload shifts in
// (R17) preload latches pattern into parallel outputs
// (R18) extest drives latched values onto outputs
// (R19) bit 108 enables output drivers under extest
// (R20) bit 108 latch preset high at reset
// (R22) decode 000,001,010,100,111; others reserved
// (R23) standard sixteen-state tap controller
// (R24) tdo driven in shift states, and in exit1 until its falling tck
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH
`define SBST_IR_W 3
`define SBST_BSR_W 109
`define SBST_ID_W 32
`define SBST_OE_BIT 108
`define SBST_IR_CAPT 2'h1
`define SBST_I_EXTEST 3'h0
`define SBST_I_IDCODE 3'h1
`define SBST_I_SAMPZ 3'h2
`define SBST_I_SAMPLE 3'h4
`define SBST_I_BYPASS 3'h7
`define SBST_S_TLR 4'h0
`define SBST_S_RTI 4'h1
`define SBST_S_SELDR 4'h2
`define SBST_S_CAPDR 4'h3
`define SBST_S_SHDR 4'h4
`define SBST_S_EX1DR 4'h5
`define SBST_S_PADR 4'h6
`define SBST_S_EX2DR 4'h7
`define SBST_S_UPDR 4'h8
`define SBST_S_SELIR 4'h9
`define SBST_S_CAPIR 4'ha
`define SBST_S_SHIR 4'hb
`define SBST_S_EX1IR 4'hc
`define SBST_S_PAIR 4'hd
`define SBST_S_EX2IR 4'he
`define SBST_S_UPIR 4'hf
`endif

// ===== hw/sbst_skid.v
// two-entry buffer with valid/ready on both sides
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
module sbst_skid #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // sbst_skid
`default_nettype wire

// ===== hw/sbst_sync.v
// two-flop synchroniser for one level from a foreign domain
// assumes clk is the block clock, rst_n asynchronous
`timescale 1ns/1ps
`default_nettype none
module sbst_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sbst_sync
`default_nettype wire

// ===== hw/sbst_tap.v
// boundary scan tap of a synchronous sram, sampled from clk
// assumes tck, tms, tdi are asynchronous pins; tck far slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module sbst_tap #(
  parameter [`SBST_ID_W-1:0] ID_VALUE = 32'h00000001, // arbitrary value
  parameter BSR_W = `SBST_BSR_W
) (
  input wire clk,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe_n,
  input wire [BSR_W-1:0] pin_snapshot,
  output reg [BSR_W-1:0] pin_drive,
  output wire pin_drive_en,
  output wire qbus_float,
  output wire [`SBST_IR_W-1:0] active_instruction,
  output wire [3:0] tap_state
);
  // ****************************************
  // pin synchronisers and tck edges
  // ****************************************
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg tck_d_q;
  sbst_sync #(.RST_VAL(1'b0)) u_tck (.clk(clk), .rst_n(rst_n), .d(tck), .q(tck_s));
  sbst_sync #(.RST_VAL(1'b1)) u_tms (.clk(clk), .rst_n(rst_n), .d(tms), .q(tms_s));
  sbst_sync #(.RST_VAL(1'b1)) u_tdi (.clk(clk), .rst_n(rst_n), .d(tdi), .q(tdi_s));
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tck_d_q <= 1'b0;
    else
      tck_d_q <= tck_s;
  end
  wire tck_rise = tck_s && !tck_d_q; // (R5)
  wire tck_fall = !tck_s && tck_d_q; // (R5)

  // ****************************************
  // tap controller
  // ****************************************
  reg [3:0] st_q;
  reg [3:0] st_d;
  always @* begin
    st_d = st_q;
    case (st_q) // (R23)
      `SBST_S_TLR: st_d = tms_s ? `SBST_S_TLR : `SBST_S_RTI;
      `SBST_S_RTI: st_d = tms_s ? `SBST_S_SELDR : `SBST_S_RTI;
      `SBST_S_SELDR: st_d = tms_s ? `SBST_S_SELIR : `SBST_S_CAPDR;
      `SBST_S_CAPDR: st_d = tms_s ? `SBST_S_EX1DR : `SBST_S_SHDR;
      `SBST_S_SHDR: st_d = tms_s ? `SBST_S_EX1DR : `SBST_S_SHDR;
      `SBST_S_EX1DR: st_d = tms_s ? `SBST_S_UPDR : `SBST_S_PADR;
      `SBST_S_PADR: st_d = tms_s ? `SBST_S_EX2DR : `SBST_S_PADR;
      `SBST_S_EX2DR: st_d = tms_s ? `SBST_S_UPDR : `SBST_S_SHDR;
      `SBST_S_UPDR: st_d = tms_s ? `SBST_S_SELDR : `SBST_S_RTI;
      `SBST_S_SELIR: st_d = tms_s ? `SBST_S_TLR : `SBST_S_CAPIR; // (R1)
      `SBST_S_CAPIR: st_d = tms_s ? `SBST_S_EX1IR : `SBST_S_SHIR;
      `SBST_S_SHIR: st_d = tms_s ? `SBST_S_EX1IR : `SBST_S_SHIR;
      `SBST_S_EX1IR: st_d = tms_s ? `SBST_S_UPIR : `SBST_S_PAIR;
      `SBST_S_PAIR: st_d = tms_s ? `SBST_S_EX2IR : `SBST_S_PAIR;
      `SBST_S_EX2IR: st_d = tms_s ? `SBST_S_UPIR : `SBST_S_SHIR;
      `SBST_S_UPIR: st_d = tms_s ? `SBST_S_SELDR : `SBST_S_RTI;
      default: st_d = `SBST_S_TLR;
    endcase
  end
  // power-up reset goes straight to test-logic-reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      st_q <= `SBST_S_TLR; // (R3)
    else if (tck_rise)
      st_q <= st_d; // (R1)
  end
  assign tap_state = st_q;

  // ****************************************
  // instruction and data registers
  // ****************************************
  reg [`SBST_IR_W-1:0] ir_sh_q;
  reg [`SBST_IR_W-1:0] ir_q;
  reg byp_q;
  reg [`SBST_ID_W-1:0] id_sh_q;
  reg [BSR_W-1:0] bsr_q;
  reg oe_latch_q;
  wire in_tlr = (st_q == `SBST_S_TLR);
  // only the output-enable cell comes up set, so the q-bus drives after reset
  localparam [BSR_W-1:0] DRV_RST = {{(BSR_W-1){1'b0}}, 1'b1} << `SBST_OE_BIT;
  // reserved codes fall back to bypass so a path always exists
  function [1:0] sel_of;
    input [`SBST_IR_W-1:0] ins;
    begin
      case (ins) // (R22)
        `SBST_I_EXTEST, `SBST_I_SAMPZ, `SBST_I_SAMPLE: sel_of = 2'h2;
        `SBST_I_IDCODE: sel_of = 2'h1;
        default: sel_of = 2'h0;
      endcase
    end
  endfunction
  wire [1:0] sel = sel_of(ir_q); // (R4)
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_q <= `SBST_I_IDCODE;
      ir_q <= `SBST_I_IDCODE; // (R6)
      byp_q <= 1'b0;
      id_sh_q <= {`SBST_ID_W{1'b0}};
      bsr_q <= {BSR_W{1'b0}};
      pin_drive <= DRV_RST; // (R20)
      oe_latch_q <= 1'b1; // (R20)
    end else if (in_tlr) begin
      // held every clk in reset state, not only on tck edges
      ir_q <= `SBST_I_IDCODE; // (R6)
      oe_latch_q <= 1'b1; // (R20)
      pin_drive[`SBST_OE_BIT] <= 1'b1; // (R20)
    end else if (tck_rise) begin
      case (st_q)
        `SBST_S_CAPIR: ir_sh_q <= {ir_q[`SBST_IR_W-1], `SBST_IR_CAPT}; // (R7)
        `SBST_S_SHIR: ir_sh_q <= {tdi_s, ir_sh_q[`SBST_IR_W-1:1]};
        `SBST_S_UPIR: ir_q <= ir_sh_q; // (R12)
        `SBST_S_CAPDR: begin
          case (sel)
            2'h2: bsr_q <= pin_snapshot; // (R9) (R15)
            2'h1: id_sh_q <= ID_VALUE; // (R11)
            default: byp_q <= 1'b0; // (R8)
          endcase
        end
        `SBST_S_SHDR: begin
          case (sel)
            2'h2: bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]}; // (R10) (R16)
            2'h1: id_sh_q <= {tdi_s, id_sh_q[`SBST_ID_W-1:1]};
            default: byp_q <= tdi_s; // (R8)
          endcase
        end
        `SBST_S_UPDR: begin
          if (sel == 2'h2 && ir_q != `SBST_I_SAMPZ) begin
            pin_drive <= bsr_q; // (R17)
            oe_latch_q <= bsr_q[`SBST_OE_BIT]; // (R19)
          end
        end
        default: ;
      endcase
    end
  end
  assign active_instruction = ir_q;
  // normal sram path untouched unless extest or sample-z is active
  assign pin_drive_en = (ir_q == `SBST_I_EXTEST); // (R18) (R2)
  assign qbus_float = (ir_q == `SBST_I_SAMPZ) || (pin_drive_en && !oe_latch_q); // (R14) (R19)

  // ****************************************
  // serial output on falling tck
  // ****************************************
  wire shift_ir = (st_q == `SBST_S_SHIR);
  wire shift_dr = (st_q == `SBST_S_SHDR);
  wire dr_bit = (sel == 2'h2) ? bsr_q[0] : (sel == 2'h1) ? id_sh_q[0] : byp_q;
  wire tdo_next = shift_ir ? ir_sh_q[0] : dr_bit;
  // buffer decouples serial bit selection from the falling-edge launch
  wire buf_valid;
  wire buf_data;
  wire buf_in_ready;
  wire bit_vld = tck_fall && (shift_ir || shift_dr);
  sbst_skid #(.W(1)) u_buf (
    .clk(clk), .rst_n(rst_n),
    .in_valid(bit_vld), .in_ready(buf_in_ready), .in_data(tdo_next),
    .out_valid(buf_valid), .out_ready(1'b1), .out_data(buf_data)
  );
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1; // (R3)
    end else begin
      if (buf_valid)
        tdo <= buf_data; // (R5)
      if (tck_fall)
        tdo_oe_n <= !(shift_ir || shift_dr); // (R24)
    end
  end
  // in_ready always high here since the drain never stalls
  wire unused_ok = buf_in_ready;
endmodule // sbst_tap
`default_nettype wire

// ===== tb/sbst_ctl_model.sv
// partner: board test controller on the tap pins
// assumes tasks entered 1 ns after a clk rising edge
`timescale 1ns/1ps
`default_nettype none
module sbst_ctl_model (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  // ****
  // pin sequencing
  // ****
  // tck rests low between frames; tms and tdi rest high as the pull-ups would
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // tdo read just before the fall, long after the previous fall updated it
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #200 tck = 1'b1;
    #399 o = tdo;
    #1 tck = 1'b0;
    #200;
  endtask
  task automatic reset5();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  // from run-test-idle and back; callers never pass reserved codes
  task automatic scan(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
    logic o;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule // sbst_ctl_model
`default_nettype wire

// ===== tb/sbst_tap_properties.sv
// checker: timing relations on the tap ports
// assumes binding into sbst_tap, single clk domain
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module sbst_tap_chk #(
  parameter BSR_W = `SBST_BSR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tdo_oe_n,
  input wire logic [BSR_W-1:0] pin_drive,
  input wire logic pin_drive_en,
  input wire logic qbus_float,
  input wire logic [2:0] active_instruction,
  input wire logic [3:0] tap_state
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // exit1 allowed: enable follows the falling edge after the state moves
  a_tdo_float: assert property (
    !tdo_oe_n |-> tap_state inside {`SBST_S_SHIR, `SBST_S_SHDR, `SBST_S_EX1IR, `SBST_S_EX1DR})
    else $error("tdo driven outside shift");
  a_ir_update: assert property (
    $changed(active_instruction) |-> tap_state inside {`SBST_S_UPIR, `SBST_S_TLR} ||
    $past(tap_state) inside {`SBST_S_UPIR, `SBST_S_TLR}) else $error("instruction changed early");
  a_tlr_idcode: assert property (
    $past(tap_state) == `SBST_S_TLR && tap_state == `SBST_S_TLR |-> active_instruction == `SBST_I_IDCODE)
    else $error("no idcode in reset");
  a_oe_preset: assert property (
    $past(tap_state) == `SBST_S_TLR && tap_state == `SBST_S_TLR |-> pin_drive[`SBST_OE_BIT])
    else $error("oe latch not preset");
  a_sampz_float: assert property (
    active_instruction == `SBST_I_SAMPZ |-> qbus_float) else $error("bus not floating");
  a_drive_en: assert property (
    pin_drive_en == (active_instruction == `SBST_I_EXTEST)) else $error("drive enable wrong");
  a_extest_float: assert property (
    active_instruction == `SBST_I_EXTEST |-> qbus_float == !pin_drive[`SBST_OE_BIT])
    else $error("extest float wrong");
  a_drive_latch: assert property (
    $changed(pin_drive) |-> tap_state inside {`SBST_S_UPDR, `SBST_S_TLR} ||
    $past(tap_state) inside {`SBST_S_UPDR, `SBST_S_TLR}) else $error("latch moved early");
  a_tlr_exit: assert property (
    $past(tap_state) == `SBST_S_TLR && tap_state != `SBST_S_TLR |-> tap_state == `SBST_S_RTI)
    else $error("bad exit from reset");
endmodule // sbst_tap_chk
bind sbst_tap sbst_tap_chk #(.BSR_W(BSR_W)) u_chk (.clk(clk), .rst_n(rst_n), .tdo_oe_n(tdo_oe_n),
  .pin_drive(pin_drive), .pin_drive_en(pin_drive_en), .qbus_float(qbus_float),
  .active_instruction(active_instruction), .tap_state(tap_state));
`default_nettype wire

// ===== tb/test_sram_boundary_scan_tap.sv
// testbench: scan sequences through the tap
// assumes the controller model drives the tap pins
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module test_sram_boundary_scan_tap;
  localparam logic [31:0] ID = 32'h5a3c0f01; // arbitrary value
  localparam logic [108:0] P = {1'b0, {27{4'ha}}};
  localparam logic [108:0] Q = {1'b0, {27{4'h6}}};
  logic clk = 1'b0;
  logic rst_n;
  logic [108:0] pin_snapshot;
  logic [108:0] d;
  wire logic tck, tms, tdi, tdo, tdo_oe_n, pin_drive_en, qbus_float;
  wire logic [108:0] pin_drive;
  wire logic [2:0] active_instruction;
  wire logic [3:0] tap_state;
  int error_cnt = 0;
  int n_tests = 0;
  sbst_tap #(.ID_VALUE(ID)) u_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pin_snapshot(pin_snapshot), .pin_drive(pin_drive), .pin_drive_en(pin_drive_en),
    .qbus_float(qbus_float), .active_instruction(active_instruction), .tap_state(tap_state));
  sbst_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  always #50 clk = ~clk;
  // ****
  // scenarios
  // ****
  task chk(input logic [108:0] got, input logic [108:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task load(input logic [2:0] c);
    u_ctl.scan(1'b1, 3, {106'h0, c}, d);
    chk(d[1:0], 2'b01);
    chk(active_instruction, c);
  endtask
  task t_reset();
    chk(tap_state, `SBST_S_TLR);
    chk(active_instruction, `SBST_I_IDCODE);
    chk(tdo_oe_n, 1'b1);
    chk(pin_drive[108], 1'b1);
    u_ctl.reset5();
    u_ctl.scan(1'b0, 32, 109'h0, d);
    chk(d[31:0], ID);
    $display("reset and id test done");
  endtask
  task t_codes();
    logic [2:0] c [5];
    c = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    foreach (c[i]) load(c[i]);
    u_ctl.scan(1'b0, 4, 109'hb, d);
    chk(d[3:0], 4'h6);
    $display("code and bypass test done");
  endtask
  task t_preload();
    pin_snapshot = P;
    load(`SBST_I_SAMPLE);
    u_ctl.scan(1'b0, 109, Q, d);
    chk(d, P);
    chk(pin_drive, Q);
    load(`SBST_I_EXTEST);
    chk(pin_drive, Q);
    chk(qbus_float, 1'b1);
    load(`SBST_I_SAMPZ);
    chk(qbus_float, 1'b1);
    $display("preload test done");
  endtask
  task t_tmsrst();
    logic o;
    u_ctl.step(1'b1, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.reset5();
    chk(active_instruction, `SBST_I_IDCODE);
    chk(pin_drive[108], 1'b1);
    chk(qbus_float, 1'b0);
    $display("mid-shift reset test done");
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    pin_snapshot = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_codes();
    t_preload();
    t_tmsrst();
    print_verdict();
  end
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_sram_boundary_scan_tap
`default_nettype wire
